// [verilog/lhcp_pkg.sv]
// package for the line interface host control port
// holds pin bundle layout, frame sizes and serial state encoding
`default_nettype none

package lhcp_pkg;

  localparam int unsigned LHCP_ADDR_W = 8;
  localparam int unsigned LHCP_DATA_W = 8;
  localparam int unsigned LHCP_SYNC_STAGES = 2;

  // serial frame: one read/write bit, then address, then data, msb first
  localparam logic [4:0] LHCP_HDR_BITS = 5'h09;
  localparam logic [4:0] LHCP_FRAME_BITS = 5'h11;
  localparam logic LHCP_SER_READ = 1'h1;

  // static select pin levels
  localparam logic LHCP_IF_SERIAL = 1'h0;
  localparam logic LHCP_STYLE_SINGLE = 1'h0;
  localparam logic LHCP_RW_WRITE = 1'h0;
  localparam logic LHCP_EDGE_RISE = 1'h0;

  localparam logic [LHCP_DATA_W-1:0] LHCP_DATA_RST = 8'h00;
  localparam logic [LHCP_ADDR_W-1:0] LHCP_ADDR_RST = 8'h00;

  // every pin that arrives from the host, as one bundle for synchronising
  typedef struct packed {
    logic cs_n;
    logic if_select;
    logic bus_style_select;
    logic data_strobe_n;
    logic rw_select;
    logic shift_clk;
    logic serial_in;
    logic out_edge_select;
    logic [LHCP_ADDR_W-1:0] addr;
    logic [LHCP_DATA_W-1:0] data;
  } lhcp_pins_t;

  // levels of an idle host; synchroniser resets here so no false select follows reset
  localparam lhcp_pins_t LHCP_PINS_IDLE = '{cs_n: 1'h1, data_strobe_n: 1'h1, rw_select: 1'h1,
    default: '0};

  // user side register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [LHCP_ADDR_W-1:0] addr;
    logic [LHCP_DATA_W-1:0] wdata;
  } lhcp_req_t;

  typedef enum logic [1:0] {
    LHCP_SER_IDLE = 2'h0,
    LHCP_SER_HDR = 2'h1,
    LHCP_SER_DATA = 2'h3,
    LHCP_SER_DONE = 2'h2
  } lhcp_ser_state_t;

endpackage : lhcp_pkg

`default_nettype wire

// [verilog/lhcp_sync.sv]
// two stage synchroniser for a bundle of asynchronous inputs
// assumes each bit is a level; multi-bit buses must be stable while sampled
`default_nettype none

module lhcp_sync #(
  parameter int unsigned W = 1,
  // idle level of each input, so reset does not look like activity
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // async in, synced out
  input wire logic [W-1:0] d_async,
  output logic [W-1:0] q_sync
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= d_async;
      sync_reg <= meta_reg;
    end
  end

  assign q_sync = sync_reg;

endmodule : lhcp_sync

`default_nettype wire

// [verilog/lhcp_host_port.sv]
// host control port: serial or parallel access to device registers
// assumes reg_rdata is combinational from req.addr on clk_sys, and that
// host strobes and shift clock are slow against clk_sys (several cycles per phase)
//
// Behaviour
// - select pin low serial, high parallel
// - serial uses select, clock, in, out, edge
// - parallel non-multiplexed, 8-bit address and data
// - style pin low single strobe, high dual
// - serial input sampled on shift clock rise
// - serial output edge chosen by edge pin
// - single strobe: select 0 write, 1 read
// - read strobe low drives addressed data out
// - write strobe low, device captures data bus
`default_nettype none

module lhcp_host_port
  import lhcp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host pins, asynchronous
  input wire lhcp_pins_t pins,
  // serial output pin
  output logic serial_out,
  output logic serial_out_oe,
  // parallel data bus drive
  output logic [LHCP_DATA_W-1:0] data_out,
  output logic data_oe,
  // register access
  output lhcp_req_t req,
  input wire logic [LHCP_DATA_W-1:0] reg_rdata
);

  // ************************************************************
  // input synchronisation
  // ************************************************************

  lhcp_pins_t s;

  lhcp_sync #(
    .W($bits(lhcp_pins_t)),
    .RST_VAL(LHCP_PINS_IDLE)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d_async(pins),
    .q_sync(s)
  );

  logic sclk_d_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_reg <= 1'h0;
    end else begin
      sclk_d_reg <= s.shift_clk;
    end
  end

  logic ser_mode;
  assign ser_mode = (s.if_select == LHCP_IF_SERIAL);
  logic sel;
  assign sel = !s.cs_n;

  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = s.shift_clk && !sclk_d_reg;
  assign sclk_fall = !s.shift_clk && sclk_d_reg;

  // ************************************************************
  // parallel access decode
  // ************************************************************

  logic rd_act;
  logic wr_act;
  always_comb begin
    rd_act = 1'h0;
    wr_act = 1'h0;
    if (!ser_mode && sel) begin
      if (s.bus_style_select == LHCP_STYLE_SINGLE) begin
        rd_act = !s.data_strobe_n && (s.rw_select != LHCP_RW_WRITE);
        wr_act = !s.data_strobe_n && (s.rw_select == LHCP_RW_WRITE);
      end else begin
        rd_act = !s.data_strobe_n;
        wr_act = !s.rw_select;
      end
    end
  end

  logic rd_act_reg;
  logic wr_act_reg;
  logic [LHCP_DATA_W-1:0] par_wdata_reg;
  logic [LHCP_ADDR_W-1:0] par_addr_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_act_reg <= 1'h0;
      wr_act_reg <= 1'h0;
    end else begin
      rd_act_reg <= rd_act;
      wr_act_reg <= wr_act;
    end
  end

  // bus sampled every cycle of the write; last value before release wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      par_wdata_reg <= LHCP_DATA_RST;
      par_addr_reg <= LHCP_ADDR_RST;
    end else if (rd_act || wr_act) begin
      par_addr_reg <= s.addr;
      if (wr_act) begin
        par_wdata_reg <= s.data;
      end
    end
  end

  logic par_rd_start;
  logic par_wr_end;
  assign par_rd_start = rd_act && !rd_act_reg;
  // write commits on strobe release so the data had time to settle
  assign par_wr_end = wr_act_reg && !wr_act;

  // ************************************************************
  // serial frame engine
  // ************************************************************

  lhcp_ser_state_t ser_state_reg;
  logic [4:0] bit_cnt_reg;
  logic [LHCP_DATA_W:0] shin_reg;
  logic ser_read_reg;
  logic [LHCP_ADDR_W-1:0] ser_addr_reg;
  logic ser_active;
  assign ser_active = ser_mode && sel;

  logic ser_hdr_done;
  logic ser_frame_done;
  assign ser_hdr_done = sclk_rise && (ser_state_reg == LHCP_SER_HDR)
    && (bit_cnt_reg == LHCP_HDR_BITS - 5'h01);
  assign ser_frame_done = sclk_rise && (ser_state_reg == LHCP_SER_DATA)
    && (bit_cnt_reg == LHCP_FRAME_BITS - 5'h01);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ser_state_reg <= LHCP_SER_IDLE;
      bit_cnt_reg <= 5'h00;
      shin_reg <= '0;
      ser_read_reg <= 1'h0;
      ser_addr_reg <= LHCP_ADDR_RST;
    end else if (!ser_active) begin
      // deselect aborts any partial frame
      ser_state_reg <= LHCP_SER_IDLE;
      bit_cnt_reg <= 5'h00;
    end else begin
      case (ser_state_reg)
        LHCP_SER_IDLE: begin
          ser_state_reg <= LHCP_SER_HDR;
          bit_cnt_reg <= 5'h00;
        end
        LHCP_SER_HDR, LHCP_SER_DATA: begin
          if (sclk_rise) begin
            shin_reg <= {shin_reg[LHCP_DATA_W-1:0], s.serial_in};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
          if (ser_hdr_done) begin
            ser_read_reg <= (shin_reg[LHCP_DATA_W-1] == LHCP_SER_READ);
            ser_addr_reg <= {shin_reg[LHCP_ADDR_W-2:0], s.serial_in};
            ser_state_reg <= LHCP_SER_DATA;
          end
          if (ser_frame_done) begin
            ser_state_reg <= LHCP_SER_DONE;
          end
        end
        LHCP_SER_DONE: begin
          // extra clocks ignored until deselect
          ser_state_reg <= LHCP_SER_DONE;
        end
        default: begin
          ser_state_reg <= LHCP_SER_IDLE;
        end
      endcase
    end
  end

  logic ser_rd_start;
  logic ser_wr_end;
  assign ser_rd_start = ser_active && ser_hdr_done
    && (shin_reg[LHCP_DATA_W-1] == LHCP_SER_READ);
  assign ser_wr_end = ser_active && ser_frame_done && !ser_read_reg;

  // ************************************************************
  // serial output shifter
  // ************************************************************

  logic [LHCP_DATA_W-1:0] shout_reg;
  logic shout_valid_reg;
  logic out_edge;
  logic serial_out_reg;
  logic ser_load_reg;

  // load waits a cycle: reg_rdata follows the new address only once req.rd is out
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ser_load_reg <= 1'h0;
    end else begin
      ser_load_reg <= ser_rd_start;
    end
  end

  assign out_edge = (s.out_edge_select == LHCP_EDGE_RISE) ? sclk_rise : sclk_fall;

  // new bit appears on each active edge after the header; msb first
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shout_reg <= LHCP_DATA_RST;
      shout_valid_reg <= 1'h0;
      serial_out_reg <= 1'h0;
    end else if (!ser_active) begin
      shout_valid_reg <= 1'h0;
      serial_out_reg <= 1'h0;
    end else if (ser_load_reg) begin
      shout_reg <= reg_rdata;
      shout_valid_reg <= 1'h1;
    end else if (out_edge && shout_valid_reg) begin
      serial_out_reg <= shout_reg[LHCP_DATA_W-1];
      shout_reg <= {shout_reg[LHCP_DATA_W-2:0], 1'h0};
    end
  end

  assign serial_out = serial_out_reg;
  assign serial_out_oe = ser_active;

  // ************************************************************
  // register request and parallel read data
  // ************************************************************

  lhcp_req_t req_reg;
  logic [LHCP_DATA_W-1:0] data_out_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_reg <= '0;
    end else begin
      req_reg.rd <= par_rd_start || ser_rd_start;
      req_reg.wr <= par_wr_end || ser_wr_end;
      if (ser_wr_end) begin
        req_reg.addr <= ser_addr_reg;
        req_reg.wdata <= {shin_reg[LHCP_DATA_W-2:0], s.serial_in};
      end else if (par_wr_end) begin
        req_reg.addr <= par_addr_reg;
        req_reg.wdata <= par_wdata_reg;
      end else if (par_rd_start) begin
        req_reg.addr <= s.addr;
      end else if (ser_hdr_done) begin
        req_reg.addr <= {shin_reg[LHCP_ADDR_W-2:0], s.serial_in};
      end
    end
  end

  // read data is taken every cycle of the delayed strobe, up to one cycle after the strobe release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_out_reg <= LHCP_DATA_RST;
    end else if (rd_act_reg && !ser_mode) begin
      data_out_reg <= reg_rdata;
    end
  end

  // during the strobe, reads address the bus address registered one cycle earlier
  logic [LHCP_ADDR_W-1:0] rd_addr_unused;
  assign rd_addr_unused = par_addr_reg;

  assign req = ser_active ? req_reg : (rd_act ? {req_reg.wr, req_reg.rd, rd_addr_unused,
    req_reg.wdata} : req_reg);
  assign data_out = data_out_reg;
  assign data_oe = rd_act && rd_act_reg;

endmodule : lhcp_host_port

`default_nettype wire

// [dv/lhcp_sva.sv]
// assertions on the host port
// bound to lhcp_host_port; sees its ports only
`default_nettype none
module lhcp_sva
  import lhcp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host side
  input wire lhcp_pins_t pins,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic [LHCP_DATA_W-1:0] data_out,
  input wire logic data_oe,
  // register side
  input wire lhcp_req_t req,
  input wire logic [LHCP_DATA_W-1:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_SER_OE: assert property (serial_out_oe |->
    !$past(pins.if_select, 2) && !$past(pins.cs_n, 2)) else $error("serial drive bad");
  AST_NO_SER_BUS: assert property (!pins.if_select [*4] |-> !data_oe)
    else $error("bus driven in serial mode");
  AST_SINGLE_RD: assert property (pins.if_select && !pins.bus_style_select &&
    !pins.cs_n && !pins.data_strobe_n && pins.rw_select [*5] |-> data_oe)
    else $error("single read not driven");
  AST_DUAL_RD: assert property (pins.if_select && pins.bus_style_select &&
    !pins.cs_n && !pins.data_strobe_n [*5] |-> data_oe) else $error("dual read not driven");
  AST_BUS_CS: assert property (data_oe |-> !$past(pins.cs_n, 3))
    else $error("bus driven without select");
  AST_IDLE_BUS: assert property (pins.cs_n [*4] |-> !data_oe)
    else $error("bus driven while idle");
  AST_WR_BUS: assert property (pins.if_select && !pins.bus_style_select &&
    !pins.rw_select [*4] |-> !data_oe) else $error("bus driven in write");
  AST_WR_DATA: assert property (req.wr && $past(pins.if_select, 4) |->
    req.wdata == $past(pins.data, 5)) else $error("write data wrong");
  AST_WR_PULSE: assert property (req.wr |=> !req.wr)
    else $error("write pulse too long");
  AST_RD_PULSE: assert property (req.rd |=> !req.rd)
    else $error("read pulse too long");
  AST_RD_DATA: assert property (data_oe && $past(data_oe) |->
    data_out == $past(reg_rdata)) else $error("read data wrong");
endmodule : lhcp_sva

bind lhcp_host_port lhcp_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe), .data_out(data_out),
  .data_oe(data_oe), .req(req), .reg_rdata(reg_rdata));
`default_nettype wire

// [dv/lhcp_host_model.sv]
// host controller model driving the port pins
// tasks are called from the bench; pins change at falling clk_sys
`default_nettype none
module lhcp_host_model
  import lhcp_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // pins toward the port
  output wire lhcp_pins_t pins,
  input wire logic serial_out,
  input wire logic [LHCP_DATA_W-1:0] data_out,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  lhcp_pins_t p = '{cs_n: 1'h1, data_strobe_n: 1'h1, rw_select: 1'h1, default: '0};
  // no pull on the bus: idle host flips its pattern instead
  assign pins = data_oe ? {p[23:8], data_out} : p;

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic par(input logic st, rd, input logic [7:0] a, d, output logic [7:0] q);
    p.if_select = 1'h1;
    p.bus_style_select = st;
    p.addr = a;
    p.data = d;
    p.cs_n = 1'h0;
    p.rw_select = st | rd;
    cyc(3);
    if (st && !rd) p.rw_select = 1'h0;
    else p.data_strobe_n = 1'h0;
    cyc(6);
    q = pins.data;
    p.data_strobe_n = 1'h1;
    if (st) p.rw_select = 1'h1;
    cyc(3);
    p.cs_n = 1'h1;
    p.rw_select = 1'h1;
    p.data = ~p.data;
    cyc(3);
  endtask : par

  task automatic ser(input logic es, rd, input logic [7:0] a, d, output logic [7:0] q);
    logic [16:0] f;
    f = {rd, a, d};
    p.if_select = 1'h0;
    p.out_edge_select = es;
    p.shift_clk = 1'h0;
    cyc(3);
    p.cs_n = 1'h0;
    for (int i = 0; i < 17; i++) begin
      p.serial_in = f[16-i];
      cyc(4);
      if (!es && i >= 10) q = {q[6:0], serial_out};
      p.shift_clk = 1'h1;
      cyc(4);
      if (es && i >= 9) q = {q[6:0], serial_out};
      p.shift_clk = 1'h0;
    end
    cyc(4);
    if (!es) q = {q[6:0], serial_out};
    p.cs_n = 1'h1;
    p.serial_in = ~p.serial_in;
    cyc(3);
  endtask : ser
endmodule : lhcp_host_model
`default_nettype wire

// [dv/tb_lhcp_host_port.sv]
// self-checking bench for lhcp_host_port
// host model drives pins; read data is address xor a constant
`default_nettype none
module tb_lhcp_host_port;
  import lhcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  lhcp_pins_t pins;
  logic serial_out, serial_out_oe, data_oe;
  logic [7:0] data_out, reg_rdata, q;
  lhcp_req_t req;
  logic [15:0] wr_seen;
  int fails = 0;
  int checks = 0;
  int nwr = 0;
  int nrd = 0;
  always #25 clk_sys = ~clk_sys;
  assign reg_rdata = req.addr ^ 8'hA5;
  always @(posedge clk_sys) begin
    if (req.wr) wr_seen <= {req.addr, req.wdata};
    nwr <= nwr + int'(req.wr);
    nrd <= nrd + int'(req.rd);
  end
  lhcp_host_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .data_out(data_out),
    .data_oe(data_oe), .req(req), .reg_rdata(reg_rdata));
  lhcp_host_model u_host (.clk_sys(clk_sys), .pins(pins), .serial_out(serial_out),
    .data_out(data_out), .data_oe(data_oe));

  task automatic check(input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic sc_par_wr();
    int n;
    n = nwr;
    u_host.par(1'h0, 1'h0, 8'h3C, 8'h5A, q);
    check(16'(nwr - n), 16'h1);
    check(wr_seen, 16'h3C5A);
    u_host.par(1'h1, 1'h0, 8'hFF, 8'h81, q);
    check(16'(nwr - n), 16'h2);
    check(wr_seen, 16'hFF81);
  endtask : sc_par_wr

  task automatic sc_par_rd();
    int n;
    n = nrd;
    u_host.par(1'h0, 1'h1, 8'h00, 8'h00, q);
    check(16'(q), 16'hA5);
    u_host.par(1'h1, 1'h1, 8'h7E, 8'h00, q);
    check(16'(q), 16'hDB);
    check(16'(nrd - n), 16'h2);
  endtask : sc_par_rd

  task automatic sc_ser();
    int n;
    n = nwr;
    u_host.ser(1'h0, 1'h0, 8'h81, 8'hC3, q);
    check(16'(nwr - n), 16'h1);
    check(wr_seen, 16'h81C3);
    u_host.ser(1'h0, 1'h1, 8'h12, 8'h00, q);
    check(16'(q), 16'hB7);
    u_host.ser(1'h1, 1'h1, 8'hF0, 8'h00, q);
    check(16'(q), 16'h55);
  endtask : sc_ser

  initial begin
    #2ms;
    fails++;
    end_sim();
  end

  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'h1;
    check(16'({data_oe, serial_out_oe, req.wr, req.rd}), 16'h0);
    sc_par_wr();
    sc_par_rd();
    sc_ser();
    end_sim();
  end
endmodule : tb_lhcp_host_port
`default_nettype wire
